//--- hdl/classifier_pkg.sv
// constants and types shared by the ingress classifier
// Summary of operation
// - non-static priorities pass traffic class table
// - static address table priority picks queue directly
// - default priority from default VID entry bits
// - IP precedence is top three TOS bits
// - DS table indexed by upper six bits
// - DS table not cleared; host fills first
// - tagged priority translated per ingress port
// - sixteen VLAN entries with VID, member, untag
// - entry layout VID, then untag/member pairs
// - valid tagged VID searches VLAN table
// - absent VID gives empty membership, filtered on address miss or with membership check
// - empty membership plus address miss filters
// - untagged or VID 0 uses port default
// - membership checks; untag only hybrid ports
// - two-bit state per port, host written
// - non-forwarding states discard and block
// - learning off in blocking and listening
// - forwarding state passes traffic normally
// - static plus aging entry bypasses state checks
package classifier_pkg;
    localparam int NUM_PORTS      = 3;
    localparam int VLAN_ENTRIES   = 16;
    localparam int VID_W          = 12;
    localparam int PRIO_W         = 3;
    localparam int QUEUE_W        = 2;
    localparam int DS_W           = 6;
    localparam int DS_PER_WORD    = 8;
    localparam int ENTRY_W        = 18;
    localparam int VID_LSB        = 0;
    localparam int UNTAG_LSB      = 12;
    localparam int MEMBER_LSB     = 13;
    localparam int PORT_FIELD_STEP = 2;
    localparam logic [11:0] VID_NULL = 12'h000;
    localparam logic [11:0] VID_RSVD = 12'hFFF;
    // register offsets
    localparam logic [7:0] ADDR_GLOBAL_CFG  = 8'h00;
    localparam logic [7:0] ADDR_STP_STATE   = 8'h04;
    localparam logic [7:0] ADDR_TC_TABLE    = 8'h08;
    localparam logic [7:0] ADDR_HYBRID      = 8'h0C;
    localparam logic [7:0] ADDR_REGEN_BASE  = 8'h10;
    localparam logic [7:0] ADDR_REGEN_1     = 8'h14;
    localparam logic [7:0] ADDR_REGEN_2     = 8'h18;
    localparam logic [7:0] ADDR_PORT_DEFAULT_VLAN_ID_BASE   = 8'h20;
    localparam logic [7:0] ADDR_PORT_DEFAULT_VLAN_ID_1      = 8'h24;
    localparam logic [7:0] ADDR_PORT_DEFAULT_VLAN_ID_2      = 8'h28;
    localparam logic [7:0] ADDR_VLAN_BASE   = 8'h40;
    localparam logic [7:0] ADDR_DS_BASE     = 8'h80;
    localparam logic [7:0] ADDR_STATUS      = 8'hC0;
    // global config fields
    localparam int CFG_SRC_LSB   = 0;
    localparam int CFG_STATIC_EN = 3;
    localparam int CFG_MEMB_CHK  = 4;
    localparam int CFG_VLAN_EN   = 5;
    localparam logic [31:0] CFG_RESET       = 32'h00000000;
    localparam logic [15:0] TC_RESET        = 16'hFA50;
    localparam logic [23:0] REGEN_RESET     = 24'hFAC688;
    localparam logic [5:0]  STP_RESET       = 6'h00;
    typedef enum logic [1:0] {
        STP_FORWARD  = 2'b00,
        STP_BLOCK    = 2'b01,
        STP_LEARN    = 2'b10,
        STP_LISTEN   = 2'b11
    } stp_state_e;
    typedef enum logic [2:0] {
        SRC_DEFAULT,
        SRC_IP_PREC,
        SRC_DS,
        SRC_VLAN
    } prio_src_e;
endpackage

//--- hdl/stp_gate.sv
// spanning tree decision for one port
`timescale 1ns/1ps
module stp_gate
    import classifier_pkg::*;
(
    // state
    input  wire logic [1:0] state,
    // decisions
    output logic            pass,
    output logic            learn
);
    always_comb begin
        pass  = (state == STP_FORWARD);
        learn = (state == STP_FORWARD) || (state == STP_LEARN);
    end
endmodule

//--- hdl/traffic_class_map.sv
// eight-entry priority to queue map
`timescale 1ns/1ps
module traffic_class_map
    import classifier_pkg::*;
(
    // table
    input  wire logic [15:0]        table_bits,
    // lookup
    input  wire logic [PRIO_W-1:0]  prio,
    output logic      [QUEUE_W-1:0] queue
);
    always_comb begin
        queue = table_bits[{prio, 1'b0} +: QUEUE_W];
    end
endmodule

//--- hdl/switch_ingress_classifier.sv
// ingress priority, VLAN and spanning tree classifier
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module switch_ingress_classifier
    import classifier_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    // register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    // frame descriptor in
    input  wire logic                 frm_valid,
    input  wire logic [1:0]           frm_src_port,
    input  wire logic                 frm_tagged,
    input  wire logic [VID_W-1:0]     frm_vid,
    input  wire logic [PRIO_W-1:0]    frm_tag_prio,
    input  wire logic                 frm_is_ipv4,
    input  wire logic                 frm_is_ipv6,
    input  wire logic [7:0]           frm_tos,
    input  wire logic                 frm_da_hit,
    input  wire logic                 frm_da_static,
    input  wire logic                 frm_da_age,
    input  wire logic [QUEUE_W-1:0]   frm_da_prio,
    input  wire logic [NUM_PORTS-1:0] frm_da_ports,
    // classification result
    output logic                      res_valid,
    output logic [QUEUE_W-1:0]        res_queue,
    output logic [VID_W-1:0]          res_vid,
    output logic [PRIO_W-1:0]         res_prio,
    output logic [NUM_PORTS-1:0]      res_member,
    output logic [NUM_PORTS-1:0]      res_untag,
    output logic [NUM_PORTS-1:0]      res_dest,
    output logic                      res_drop,
    output logic                      res_learn
);
    typedef struct packed {
        logic [31:0]            cfg;
        logic [5:0]             stp;
        logic [15:0]            tc;
        logic [NUM_PORTS-1:0]   hybrid;
        logic [23:0]            regen_0;
        logic [23:0]            regen_1;
        logic [23:0]            regen_2;
        logic [14:0]            port_default_vlan_id_0;
        logic [14:0]            port_default_vlan_id_1;
        logic [14:0]            port_default_vlan_id_2;
        logic [31:0]            rdata;
        logic                   valid;
        logic [QUEUE_W-1:0]     queue;
        logic [VID_W-1:0]       vid;
        logic [PRIO_W-1:0]      prio;
        logic [NUM_PORTS-1:0]   member;
        logic [NUM_PORTS-1:0]   untag;
        logic [NUM_PORTS-1:0]   dest;
        logic                   drop;
        logic                   learn;
        logic [7:0]             drop_cnt;
    } state_s;

    state_s state_q;
    state_s state_d;

    // tables kept outside the struct; only the VLAN valid flags reset, the rest on purpose not
    logic [ENTRY_W-1:0] vlan_table_q [VLAN_ENTRIES];
    logic               vlan_valid_q [VLAN_ENTRIES];
    logic [PRIO_W-1:0]  ds_table_q   [64];

    function automatic logic [14:0] pick_port_default_vlan_id(input logic [1:0] port, input state_s s);
        logic [14:0] r;
        r = s.port_default_vlan_id_0;
        if (port == 2'd1) begin
            r = s.port_default_vlan_id_1;
        end else if (port == 2'd2) begin
            r = s.port_default_vlan_id_2;
        end
        return r;
    endfunction

    function automatic logic [23:0] pick_regen(input logic [1:0] port, input state_s s);
        logic [23:0] r;
        r = s.regen_0;
        if (port == 2'd1) begin
            r = s.regen_1;
        end else if (port == 2'd2) begin
            r = s.regen_2;
        end
        return r;
    endfunction

    function automatic logic [NUM_PORTS-1:0] port_bit(input logic [1:0] port);
        return NUM_PORTS'(1) << port;
    endfunction

    // one flag per port, two bits apart
    function automatic logic [NUM_PORTS-1:0] entry_ports(input logic [ENTRY_W-1:0] e, input int lsb);
        logic [NUM_PORTS-1:0] r;
        for (int p = 0; p < NUM_PORTS; p++) begin
            r[p] = e[lsb + PORT_FIELD_STEP*p];
        end
        return r;
    endfunction

    function automatic logic is_vlan_addr(input logic [7:0] a);
        return a[7:6] == ADDR_VLAN_BASE[7:6];
    endfunction

    // eight DS entries per word: all 64 reachable
    function automatic logic is_ds_addr(input logic [7:0] a);
        return a[7:5] == ADDR_DS_BASE[7:5];
    endfunction

    // spanning tree per port
    logic [NUM_PORTS-1:0] port_pass;
    logic [NUM_PORTS-1:0] port_learn;
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_stp
        stp_gate u_stp (
            .state (state_q.stp[2*p +: 2]),
            .pass  (port_pass[p]),
            .learn (port_learn[p])
        );
    end

    // priority selection
    logic [14:0]       port_default_vlan_id_entry;
    logic [23:0]       regen_row;
    logic [PRIO_W-1:0] sel_prio;
    logic [QUEUE_W-1:0] tc_queue;
    logic              use_default;
    logic [VID_W-1:0]  eff_vid;
    prio_src_e         src_sel;

    always_comb begin
        port_default_vlan_id_entry  = pick_port_default_vlan_id(frm_src_port, state_q);
        regen_row   = pick_regen(frm_src_port, state_q);
        use_default = !frm_tagged || (frm_vid == VID_NULL);
        eff_vid     = use_default ? port_default_vlan_id_entry[VID_W-1:0] : frm_vid;
        src_sel     = prio_src_e'(state_q.cfg[CFG_SRC_LSB +: 3]);
        sel_prio    = port_default_vlan_id_entry[14:12];
        case (src_sel)
            SRC_IP_PREC: begin
                if (frm_is_ipv4) begin
                    sel_prio = frm_tos[7:5];
                end
            end
            SRC_DS: begin
                if (frm_is_ipv4 || frm_is_ipv6) begin
                    sel_prio = ds_table_q[frm_tos[7:2]];
                end
            end
            // row holds three bits per tagged priority
            SRC_VLAN: begin
                if (!use_default) begin
                    sel_prio = regen_row[{frm_tag_prio, 1'b0} + {2'b00, frm_tag_prio} +: PRIO_W];
                end
            end
            default: begin
                sel_prio = port_default_vlan_id_entry[14:12];
            end
        endcase
    end

    traffic_class_map u_tc (
        .table_bits (state_q.tc),
        .prio       (sel_prio),
        .queue      (tc_queue)
    );

    // VLAN search
    logic [NUM_PORTS-1:0] vl_member;
    logic [NUM_PORTS-1:0] vl_untag;
    logic                 vl_hit;
    always_comb begin
        vl_member = '0;
        vl_untag  = '0;
        vl_hit    = 1'b0;
        if (eff_vid != VID_NULL && eff_vid != VID_RSVD) begin
            for (int i = 0; i < VLAN_ENTRIES; i++) begin
                if (vlan_valid_q[i] && vlan_table_q[i][VID_LSB +: VID_W] == eff_vid && !vl_hit) begin
                    vl_hit    = 1'b1;
                    vl_untag  = entry_ports(vlan_table_q[i], UNTAG_LSB);
                    vl_member = entry_ports(vlan_table_q[i], MEMBER_LSB);
                end
            end
        end
        // a miss leaves membership empty: foreign VLAN
    end

    // register decode and result
    logic [3:0] widx;
    logic       stp_bypass;
    logic       vlan_en;
    logic [NUM_PORTS-1:0] dest_raw;
    logic [NUM_PORTS-1:0] dest_ok;
    logic       drop_now;
    logic       src_ok;
    always_comb begin
        state_d    = state_q;
        widx       = reg_addr[5:2];
        vlan_en    = state_q.cfg[CFG_VLAN_EN];
        stp_bypass = frm_da_hit && frm_da_static && frm_da_age;
        src_ok     = int'(frm_src_port) < NUM_PORTS;
        // an address miss floods every port except the source; with VLAN on, only the member ports
        dest_raw   = frm_da_hit ? frm_da_ports : ~port_bit(frm_src_port);
        dest_raw   = dest_raw & ~port_bit(frm_src_port);
        if (vlan_en && !frm_da_hit) begin
            dest_raw = dest_raw & vl_member;
        end
        dest_ok = stp_bypass ? dest_raw : (dest_raw & port_pass);
        drop_now = 1'b0;
        if (!stp_bypass && !port_pass[frm_src_port]) begin
            drop_now = 1'b1;
        end
        if (vlan_en && state_q.cfg[CFG_MEMB_CHK] && !vl_member[frm_src_port]) begin
            drop_now = 1'b1;
        end
        if (vlan_en && !frm_da_hit && (vl_member == '0)) begin
            drop_now = 1'b1;
        end
        if (dest_ok == '0) begin
            drop_now = 1'b1;
        end
        // no port 3: drop rather than index past the vectors
        if (!src_ok) begin
            drop_now = 1'b1;
        end
        state_d.valid = frm_valid;
        if (frm_valid) begin
            // static address priority skips the class table
            state_d.queue = (state_q.cfg[CFG_STATIC_EN] && frm_da_hit && frm_da_static)
                            ? frm_da_prio : tc_queue;
            state_d.vid    = eff_vid;
            state_d.prio   = sel_prio;
            state_d.member = vl_member;
            state_d.untag  = vl_untag & state_q.hybrid;
            state_d.dest   = drop_now ? '0 : dest_ok;
            state_d.drop   = drop_now;
            state_d.learn  = src_ok && port_learn[frm_src_port];
            // drop count sticks at its top instead of wrapping
            if (drop_now && state_q.drop_cnt != 8'hFF) begin
                state_d.drop_cnt = state_q.drop_cnt + 8'h01;
            end
        end
        if (reg_wr) begin
            case (reg_addr)
                ADDR_GLOBAL_CFG: state_d.cfg    = reg_wdata;
                ADDR_STP_STATE:  state_d.stp    = reg_wdata[5:0];
                ADDR_TC_TABLE:   state_d.tc     = reg_wdata[15:0];
                ADDR_HYBRID:     state_d.hybrid = reg_wdata[NUM_PORTS-1:0];
                ADDR_REGEN_BASE: state_d.regen_0 = reg_wdata[23:0];
                ADDR_REGEN_1:    state_d.regen_1 = reg_wdata[23:0];
                ADDR_REGEN_2:    state_d.regen_2 = reg_wdata[23:0];
                ADDR_PORT_DEFAULT_VLAN_ID_BASE:  state_d.port_default_vlan_id_0 = reg_wdata[14:0];
                ADDR_PORT_DEFAULT_VLAN_ID_1:     state_d.port_default_vlan_id_1 = reg_wdata[14:0];
                ADDR_PORT_DEFAULT_VLAN_ID_2:     state_d.port_default_vlan_id_2 = reg_wdata[14:0];
                default: begin
                end
            endcase
        end
        state_d.rdata = 32'h00000000;
        // unmapped reads return zero
        if (reg_rd) begin
            case (reg_addr[7:6])
                2'b01: state_d.rdata = {13'h0000, vlan_valid_q[widx], vlan_table_q[widx]};
                2'b10: begin
                    for (int k = 0; k < DS_PER_WORD; k++) begin
                        if (is_ds_addr(reg_addr)) begin
                            state_d.rdata[PRIO_W*k +: PRIO_W] = ds_table_q[{reg_addr[4:2], 3'(k)}];
                        end
                    end
                end
                default: begin
                    case (reg_addr)
                        ADDR_GLOBAL_CFG: state_d.rdata = state_q.cfg;
                        ADDR_STP_STATE:  state_d.rdata = {26'h0000000, state_q.stp};
                        ADDR_TC_TABLE:   state_d.rdata = {16'h0000, state_q.tc};
                        ADDR_HYBRID:     state_d.rdata = {29'h00000000, state_q.hybrid};
                        ADDR_REGEN_BASE: state_d.rdata = {8'h00, state_q.regen_0};
                        ADDR_REGEN_1:    state_d.rdata = {8'h00, state_q.regen_1};
                        ADDR_REGEN_2:    state_d.rdata = {8'h00, state_q.regen_2};
                        ADDR_PORT_DEFAULT_VLAN_ID_BASE:  state_d.rdata = {17'h00000, state_q.port_default_vlan_id_0};
                        ADDR_PORT_DEFAULT_VLAN_ID_1:     state_d.rdata = {17'h00000, state_q.port_default_vlan_id_1};
                        ADDR_PORT_DEFAULT_VLAN_ID_2:     state_d.rdata = {17'h00000, state_q.port_default_vlan_id_2};
                        ADDR_STATUS:     state_d.rdata = {21'h000000, port_learn, state_q.drop_cnt};
                        default:         state_d.rdata = 32'h00000000;
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q         <= '0;
            state_q.cfg     <= CFG_RESET;
            state_q.stp     <= STP_RESET;
            state_q.tc      <= TC_RESET;
            state_q.regen_0 <= REGEN_RESET;
            state_q.regen_1 <= REGEN_RESET;
            state_q.regen_2 <= REGEN_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // VLAN entries clear their valid flag at reset; DS table never does
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < VLAN_ENTRIES; i++) begin
                vlan_valid_q[i] <= 1'b0;
            end
        end else if (reg_wr && is_vlan_addr(reg_addr)) begin
            vlan_valid_q[widx] <= reg_wdata[ENTRY_W];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reg_wr && is_vlan_addr(reg_addr)) begin
            vlan_table_q[widx] <= reg_wdata[ENTRY_W-1:0];
        end
        if (reg_wr && is_ds_addr(reg_addr)) begin
            for (int k = 0; k < DS_PER_WORD; k++) begin
                ds_table_q[{reg_addr[4:2], 3'(k)}] <= reg_wdata[PRIO_W*k +: PRIO_W];
            end
        end
    end

    assign reg_rdata  = state_q.rdata;
    assign res_valid  = state_q.valid;
    assign res_queue  = state_q.queue;
    assign res_vid    = state_q.vid;
    assign res_prio   = state_q.prio;
    assign res_member = state_q.member;
    assign res_untag  = state_q.untag;
    assign res_dest   = state_q.dest;
    assign res_drop   = state_q.drop;
    assign res_learn  = state_q.learn;
endmodule

//--- verification/ingress_classifier_props.sv
// concurrent checks on the ingress classifier ports
`timescale 1ns/1ps
module ingress_classifier_props
    import classifier_pkg::*;
(
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    // frame in
    input wire logic        frm_valid,
    input wire logic [1:0]  frm_src_port,
    input wire logic        frm_tagged,
    input wire logic [11:0] frm_vid,
    input wire logic        frm_is_ipv4,
    input wire logic [7:0]  frm_tos,
    input wire logic        frm_da_hit,
    input wire logic        frm_da_static,
    input wire logic        frm_da_age,
    input wire logic [1:0]  frm_da_prio,
    input wire logic [2:0]  frm_da_ports,
    // result
    input wire logic        res_valid,
    input wire logic [1:0]  res_queue,
    input wire logic [11:0] res_vid,
    input wire logic [2:0]  res_prio,
    input wire logic [2:0]  res_untag,
    input wire logic        res_drop,
    input wire logic        res_learn
);
    logic [7:0]  cfg_q;
    logic [5:0]  stp_q;
    logic [15:0] tc_q;
    logic [2:0]  hyb_q;
    logic [1:0]  src_st;
    logic        stat_path;
    logic        ovr;
    assign src_st    = 2'(stp_q >> (2 * frm_src_port));
    assign stat_path = cfg_q[3] && frm_da_hit && frm_da_static;
    assign ovr       = frm_da_hit && frm_da_static && frm_da_age;
    // shadow of host writes, internal registers are out of reach here
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_q <= 8'h00;
            stp_q <= STP_RESET;
            tc_q  <= TC_RESET;
            hyb_q <= 3'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_GLOBAL_CFG: cfg_q <= reg_wdata[7:0];
                ADDR_STP_STATE:  stp_q <= reg_wdata[5:0];
                ADDR_TC_TABLE:   tc_q <= reg_wdata[15:0];
                ADDR_HYBRID:     hyb_q <= reg_wdata[2:0];
                default:         ;
            endcase
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    chk_static_queue: assert property (frm_valid && stat_path |=> res_queue == $past(frm_da_prio))
        else $error("static queue not taken from address entry");
    chk_tc_map: assert property (frm_valid && cfg_q[2:0] == 3'h1 && frm_is_ipv4 && !stat_path
        |=> res_queue == 2'($past(tc_q) >> (2 * $past(frm_tos[7:5]))))
        else $error("queue differs from class table");
    chk_ip_prec: assert property (frm_valid && cfg_q[2:0] == 3'h1 && frm_is_ipv4 && !stat_path
        |=> res_prio == $past(frm_tos[7:5]))
        else $error("precedence priority wrong");
    chk_learn_state: assert property (frm_valid |=> res_learn == !$past(src_st[0]))
        else $error("learn enable wrong for port state");
    chk_stp_drop: assert property (frm_valid && src_st != 2'h0 && !ovr |=> res_drop)
        else $error("frame from non-forwarding port kept");
    chk_vid_tagged: assert property (frm_valid && cfg_q[5] && frm_tagged && frm_vid != VID_NULL
        && frm_vid != VID_RSVD |=> res_vid == $past(frm_vid))
        else $error("tagged vid not carried");
    chk_untag_hybrid: assert property (res_valid |-> (res_untag & ~$past(hyb_q)) == 3'h0)
        else $error("untag on non-hybrid port");
    chk_override_fwd: assert property (frm_valid && ovr && !cfg_q[4]
        && (frm_da_ports & ~(3'h1 << frm_src_port)) != 3'h0 |=> !res_drop)
        else $error("override entry frame dropped");
    cover property (frm_valid && stat_path);
    cover property (frm_valid && ovr && src_st != 2'h0);
    cover property (res_valid && res_drop);
endmodule

bind switch_ingress_classifier ingress_classifier_props u_props (.clk_sys, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .frm_valid, .frm_src_port, .frm_tagged, .frm_vid, .frm_is_ipv4, .frm_tos, .frm_da_hit,
    .frm_da_static, .frm_da_age, .frm_da_prio, .frm_da_ports, .res_valid, .res_queue, .res_vid, .res_prio,
    .res_untag, .res_drop, .res_learn);

//--- verification/tb_switch_ingress_classifier.sv
// self-checking bench for the ingress classifier
`timescale 1ns/1ps
module tb_switch_ingress_classifier
    import classifier_pkg::*;
;
    typedef struct {
        logic [7:0]  cfg;
        logic        tg;
        logic [11:0] vid;
        logic [2:0]  tp;
        logic [7:0]  tos;
        logic [1:0]  ip;
        logic [1:0]  da;
        logic [2:0]  dp;
        logic [1:0]  q;
        logic [11:0] ev;
        logic [2:0]  mem;
        logic [2:0]  ut;
        logic        drp;
    } row_s;
    logic        clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, frm_valid = 1'b0;
    logic [7:0]  reg_addr = 8'h00, frm_tos = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
    logic [1:0]  frm_src_port = 2'h1, frm_da_prio = 2'h1, res_queue;
    logic        frm_tagged = 1'b0, frm_is_ipv4 = 1'b0, frm_is_ipv6 = 1'b0, res_valid, res_drop, res_learn;
    logic        frm_da_hit = 1'b0, frm_da_static = 1'b0, frm_da_age = 1'b0;
    logic [11:0] frm_vid = 12'h0, res_vid;
    logic [2:0]  frm_tag_prio = 3'h0, frm_da_ports = 3'h0, res_prio, res_member, res_untag, res_dest;
    int          n_fail = 0, samples_checked = 0;
    row_s        x;
    // class table written as 4E1B: prio 0..7 -> queue 3,2,1,0,2,3,0,1
    row_s rows [12] = '{
        '{8'h20, 1'b0, 12'h000, 3'h0, 8'h00, 2'h0, 2'h0, 3'h0, 2'h3, 12'h005, 3'h3, 3'h2, 1'b0},
        '{8'h21, 1'b1, 12'h005, 3'h0, 8'hC0, 2'h1, 2'h0, 3'h0, 2'h0, 12'h005, 3'h3, 3'h2, 1'b0},
        '{8'h21, 1'b0, 12'h000, 3'h0, 8'hE0, 2'h1, 2'h0, 3'h0, 2'h1, 12'h005, 3'h3, 3'h2, 1'b0},
        '{8'h22, 1'b0, 12'h000, 3'h0, 8'h17, 2'h1, 2'h0, 3'h0, 2'h3, 12'h005, 3'h3, 3'h2, 1'b0},
        '{8'h22, 1'b0, 12'h000, 3'h0, 8'h1A, 2'h2, 2'h0, 3'h0, 2'h0, 12'h005, 3'h3, 3'h2, 1'b0},
        '{8'h23, 1'b1, 12'h005, 3'h6, 8'h00, 2'h0, 2'h0, 3'h0, 2'h2, 12'h005, 3'h3, 3'h2, 1'b0},
        '{8'h20, 1'b1, 12'h000, 3'h4, 8'h00, 2'h0, 2'h0, 3'h0, 2'h3, 12'h005, 3'h3, 3'h2, 1'b0},
        '{8'h28, 1'b0, 12'h000, 3'h0, 8'h00, 2'h0, 2'h3, 3'h1, 2'h1, 12'h005, 3'h3, 3'h2, 1'b0},
        '{8'h20, 1'b1, 12'h123, 3'h0, 8'h00, 2'h0, 2'h2, 3'h4, 2'h3, 12'h123, 3'h4, 3'h0, 1'b0},
        '{8'h20, 1'b1, 12'h3AB, 3'h0, 8'h00, 2'h0, 2'h0, 3'h0, 2'h3, 12'h3AB, 3'h0, 3'h0, 1'b1},
        '{8'h30, 1'b1, 12'h3AB, 3'h0, 8'h00, 2'h0, 2'h2, 3'h4, 2'h3, 12'h3AB, 3'h0, 3'h0, 1'b1},
        '{8'h30, 1'b1, 12'h123, 3'h0, 8'h00, 2'h0, 2'h2, 3'h4, 2'h3, 12'h123, 3'h4, 3'h0, 1'b1}};

    switch_ingress_classifier dut (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .frm_valid, .frm_src_port, .frm_tagged, .frm_vid, .frm_tag_prio, .frm_is_ipv4, .frm_is_ipv6, .frm_tos,
        .frm_da_hit, .frm_da_static, .frm_da_age, .frm_da_prio, .frm_da_ports, .res_valid, .res_queue,
        .res_vid, .res_prio, .res_member, .res_untag, .res_dest, .res_drop, .res_learn);

    always #20 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic send(input row_s r, input logic age);
        @(posedge clk_sys);
        frm_valid    <= 1'b1;
        frm_tagged   <= r.tg;
        frm_vid      <= r.vid;
        frm_tag_prio <= r.tp;
        frm_tos      <= r.tos;
        {frm_is_ipv6, frm_is_ipv4} <= r.ip;
        {frm_da_hit, frm_da_static} <= r.da;
        frm_da_ports <= r.dp;
        frm_da_age   <= age;
        @(posedge clk_sys);
        frm_valid    <= 1'b0;
        #1;
        chk(res_valid, 1'b1);
    endtask
    task automatic complete_run();
        $display("samples_checked=%0d n_fail=%0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wr(ADDR_TC_TABLE, 32'h4E1B);
        wr(ADDR_HYBRID, 32'h2);
        wr(ADDR_REGEN_BASE + 8'h04, 32'h53977);
        wr(ADDR_PORT_DEFAULT_VLAN_ID_BASE + 8'h04, 32'h5005);
        wr(ADDR_VLAN_BASE, 32'h4E005);
        wr(ADDR_VLAN_BASE + 8'h04, 32'h70123);
        // each DS word: entry n holds n mod 8
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_DS_BASE + 8'(4 * i), 32'hFAC688);
        end
        foreach (rows[i]) begin
            wr(ADDR_GLOBAL_CFG, {24'h0, rows[i].cfg});
            send(rows[i], 1'b0);
            chk(res_queue, rows[i].q);
            chk(res_vid, rows[i].ev);
            chk(res_member, rows[i].mem);
            chk(res_untag, rows[i].ut);
            chk(res_drop, rows[i].drp);
        end
        wr(ADDR_GLOBAL_CFG, 32'h20);
        x = rows[0];
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_STP_STATE, 32'(s << 2));
            rd(ADDR_STP_STATE, d);
            chk(d, 32'(s << 2));
            rd(ADDR_STATUS, d);
            chk(d[10:8], {1'b1, !s[0], 1'b1});
            x.da = 2'h0;
            send(x, 1'b0);
            chk(res_drop, s != 0);
            chk(res_learn, !s[0]);
            x.da = 2'h3;
            x.dp = 3'h1;
            send(x, 1'b1);
            chk(res_drop, 1'b0);
        end
        // blocked egress port: frame to it must not go out
        wr(ADDR_STP_STATE, 32'h10);
        x.da = 2'h2;
        x.dp = 3'h4;
        send(x, 1'b0);
        chk({res_drop, res_dest}, 4'h8);
        wr(ADDR_STP_STATE, 32'h0);
        send(x, 1'b0);
        chk({res_drop, res_dest}, 4'h4);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk({res_valid, res_vid, res_drop}, 14'h0);
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(ADDR_TC_TABLE, d);
        chk(d, {16'h0, TC_RESET});
        rd(ADDR_GLOBAL_CFG, d);
        chk(d, CFG_RESET);
        rd(ADDR_STP_STATE, d);
        chk(d, {26'h0, STP_RESET});
        rd(ADDR_REGEN_BASE + 8'h04, d);
        chk(d, {8'h0, REGEN_RESET});
        rd(ADDR_DS_BASE + 8'h14, d);
        chk(d, 32'hFAC688);
        rd(ADDR_VLAN_BASE, d);
        chk(d, 32'h0000E005);
        rd(8'h3C, d);
        chk(d, 32'h0);
        complete_run();
    end
endmodule
